// File: pkg/eit_pkg.sv
// eit_pkg: constants and types for the edge interval timer.
// assumes a single 200 MHz clock shared by every user of the package.
package eit_pkg;
   ////////////////////////////////////////////////////////////////////////
   localparam longint CLK_HZ = 200_000_000;
   localparam longint PULSE_RES_NS = 40;
   localparam int PULSE_TICK_CYC = int'((PULSE_RES_NS * CLK_HZ + 999_999_999) / 1_000_000_000);
   localparam longint PULSE_TICK_HZ = 1_000_000_000 / PULSE_RES_NS;
   localparam longint MAX_PERIOD_NS = 2_000_000_000;
   localparam longint MAX_PERIOD_TICKS = MAX_PERIOD_NS / PULSE_RES_NS;
   localparam longint IO_BASE_US = 10;
   localparam longint IO_PER_RESULT_US = 15;
   localparam int IO_BASE_CYC = int'(IO_BASE_US * CLK_HZ / 1_000_000);
   localparam int IO_PER_RESULT_CYC = int'(IO_PER_RESULT_US * CLK_HZ / 1_000_000);
   ////////////////////////////////////////////////////////////////////////
   localparam int NUM_CH = 16;
   localparam int NUM_PULSE = 12;
   localparam int NUM_IO = 16;
   localparam int DIGITS = 8;
   localparam int DIGIT_W = 4;
   localparam int FUNC_W = 3;
   localparam int TS_W = 32;
   localparam int CNT_W = 16;
   localparam int NUM_W = 48;
   // edge codes
   localparam logic [3:0] EDGE_IO_FALL = 4'h0;
   localparam logic [3:0] EDGE_IO_RISE = 4'h1;
   localparam logic [3:0] EDGE_HF_FALL = 4'h2;
   localparam logic [3:0] EDGE_HF_RISE = 4'h3;
   localparam logic [3:0] EDGE_LL_FALL = 4'h4;
   localparam logic [3:0] EDGE_LL_RISE = 4'h5;
   // function codes, zero means no result for the channel
   localparam logic [2:0] FN_NONE = 3'h0;
   localparam logic [2:0] FN_PERIOD = 3'h1;
   localparam logic [2:0] FN_FREQ = 3'h2;
   localparam logic [2:0] FN_DLY_PREV = 3'h3;
   localparam logic [2:0] FN_DLY_CH1 = 3'h4;
   localparam logic [2:0] FN_EDGES = 3'h5;
   localparam logic [2:0] FN_EDGES_CH1 = 3'h6;
   typedef enum logic [4:0] {
      S_IDLE = 5'h01,
      S_WAIT = 5'h02,
      S_SEL = 5'h04,
      S_DIV = 5'h08,
      S_EMIT = 5'h10
   } eit_state_t;
endpackage

// File: verilog/eit_edge_interval_measure.sv
// eit_edge_interval_measure: edge timestamping and per-scan interval results.
// assumes edge/function words and scan_tick come from logic on clk; inputs are async pins.
// Operation
// - pulse input edges are timestamped in 40 ns ticks.
// - pulse periods above 2 s are reported invalid.
// - period uses last edge before scan and last edge in scan, over edge count.
// - two-channel delays are exact only for periodic or fast inputs.
// - with wait flag on general inputs, results wait until all general inputs with a requested result saw edges.
// - general input tick is 10 us plus 15 us per requested result.
// - two 8-digit edge words; digits 0-1 general inputs, 2-5 pulse inputs.
// - each digit selects rising or falling transition for its channel.
// - codes 0/1 general, 2/3 high-frequency, 4/5 low-level pulse, odd means rising.
// - one function per channel: period, frequency, delays, edge counts.
// - first word holds upper channels, second channels 8 to 1, highest digit leftmost.
`timescale 1ns/1ps
module eit_edge_interval_measure #(
   parameter int IO_BASE_CYC = eit_pkg::IO_BASE_CYC,
   parameter int IO_PER_RESULT_CYC = eit_pkg::IO_PER_RESULT_CYC
) (
   input wire logic clk,
   input wire logic reset,
   input wire logic [eit_pkg::NUM_PULSE-1:0] fast_pulse_inputs,
   input wire logic [eit_pkg::NUM_IO-1:0] io_inputs,
   input wire logic [31:0] edge_code_hi,
   input wire logic [31:0] edge_code_lo,
   input wire logic [23:0] func_code_hi,
   input wire logic [23:0] func_code_lo,
   input wire logic wait_all_results_flag,
   input wire logic scan_tick,
   output logic result_valid,
   output logic [3:0] result_chan,
   output logic [31:0] result_value,
   output logic result_bad,
   output logic scan_done,
   output logic scan_skipped,
   output logic busy
);
   localparam int N = eit_pkg::NUM_CH;
   localparam int TW = eit_pkg::TS_W;
   localparam int CW = eit_pkg::CNT_W;
   localparam int NW = eit_pkg::NUM_W;
   if (IO_BASE_CYC < 1 || IO_PER_RESULT_CYC < 1 || eit_pkg::PULSE_TICK_CYC < 1) begin : g_chk
      $error("tick counts must be at least one cycle");
   end

   ////////////////////////////////////////////////////////////////////////
   // configuration decode
   function automatic logic [3:0] digit_of(input int c);
      // second word is channels 8..1, lowest digit is channel 1
      digit_of = (c < 8) ? edge_code_lo[4*c +: 4] : edge_code_hi[4*(c-8) +: 4];
   endfunction
   function automatic logic [2:0] func_of(input int c);
      func_of = (c < 8) ? func_code_lo[3*c +: 3] : func_code_hi[3*(c-8) +: 3];
   endfunction
   function automatic logic is_pulse(input int c);
      logic [3:0] d;
      d = digit_of(c);
      // digits 2..5 pick a pulse input, only twelve exist
      is_pulse = (c < eit_pkg::NUM_PULSE) && d >= eit_pkg::EDGE_HF_FALL
                 && d <= eit_pkg::EDGE_LL_RISE;
   endfunction
   function automatic logic is_io(input int c);
      is_io = digit_of(c) <= eit_pkg::EDGE_IO_RISE;
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // input synchronisers
   logic [eit_pkg::NUM_PULSE-1:0] p_s1_r, p_s2_r, p_s3_r;
   logic [eit_pkg::NUM_IO-1:0] io_s1_r, io_s2_r, io_s3_r;
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         p_s1_r <= '0;
         p_s2_r <= '0;
         p_s3_r <= '0;
         io_s1_r <= '0;
         io_s2_r <= '0;
         io_s3_r <= '0;
      end else begin
         p_s1_r <= fast_pulse_inputs;
         p_s2_r <= p_s1_r;
         p_s3_r <= p_s2_r;
         io_s1_r <= io_inputs;
         io_s2_r <= io_s1_r;
         io_s3_r <= io_s2_r;
      end
   end

   // the low-level/contact class shares the high-frequency path here
   logic [N-1:0] edge_hit;
   always_comb begin
      for (int c = 0; c < N; c++) begin
         logic now_v, was_v;
         logic [3:0] dg;
         now_v = 1'b0;
         was_v = 1'b0;
         dg = digit_of(c);
         if (is_pulse(c)) begin
            now_v = p_s2_r[c];
            was_v = p_s3_r[c];
         end else if (is_io(c)) begin
            now_v = io_s2_r[c];
            was_v = io_s3_r[c];
         end
         // odd digit rises, even digit falls
         edge_hit[c] = dg[0] ? (now_v & ~was_v) : (~now_v & was_v);
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // timestamp bases
   logic [4:0] n_req;
   always_comb begin
      n_req = '0;
      for (int c = 0; c < N; c++) begin
         if (func_of(c) != eit_pkg::FN_NONE) begin
            n_req = n_req + 5'h01;
         end
      end
   end
   logic [7:0] p_div_r;
   logic [TW-1:0] p_ts_r;
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         p_div_r <= '0;
         p_ts_r <= '0;
      end else if (p_div_r == 8'(eit_pkg::PULSE_TICK_CYC - 1)) begin
         p_div_r <= '0;
         p_ts_r <= p_ts_r + TW'(1); // 40 ns granularity
      end else begin
         p_div_r <= p_div_r + 8'h01;
      end
   end
   logic [23:0] io_div_r;
   logic [TW-1:0] io_ts_r;
   logic [23:0] io_reload;
   assign io_reload = 24'(IO_BASE_CYC) + 24'(IO_PER_RESULT_CYC) * 24'(n_req);
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         io_div_r <= '0;
         io_ts_r <= '0;
      end else if (io_div_r + 24'h000001 >= io_reload) begin
         io_div_r <= '0;
         io_ts_r <= io_ts_r + TW'(1);
      end else begin
         io_div_r <= io_div_r + 24'h000001;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // per-channel edge records
   eit_pkg::eit_state_t state_r;
   logic snap;
   logic [TW-1:0] last_r [N];
   logic [TW-1:0] before_r [N];
   logic [CW-1:0] cnt_r [N];
   logic [CW-1:0] since1_r [N];
   logic [TW-1:0] s_last_r [N];
   logic [TW-1:0] s_before_r [N];
   logic [CW-1:0] s_cnt_r [N];
   logic [CW-1:0] s_since1_r [N];
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         for (int c = 0; c < N; c++) begin
            last_r[c] <= '0;
            before_r[c] <= '0;
            cnt_r[c] <= '0;
            since1_r[c] <= '0;
            s_last_r[c] <= '0;
            s_before_r[c] <= '0;
            s_cnt_r[c] <= '0;
            s_since1_r[c] <= '0;
         end
      end else begin
         for (int c = 0; c < N; c++) begin
            if (edge_hit[c]) begin
               last_r[c] <= is_pulse(c) ? p_ts_r : io_ts_r;
            end
            if (snap) begin
               // last edge before the new scan becomes its start point
               s_last_r[c] <= last_r[c];
               s_before_r[c] <= before_r[c];
               s_cnt_r[c] <= cnt_r[c];
               s_since1_r[c] <= since1_r[c];
               before_r[c] <= last_r[c];
               // an edge in the snapshot cycle opens the next scan's count
               cnt_r[c] <= edge_hit[c] ? CW'(1) : '0;
            end else if (edge_hit[c] && cnt_r[c] != '1) begin
               cnt_r[c] <= cnt_r[c] + CW'(1);
            end
            if (edge_hit[0]) begin
               since1_r[c] <= '0;
            end else if (edge_hit[c] && since1_r[c] != '1) begin
               since1_r[c] <= since1_r[c] + CW'(1);
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // scan sequencer and shared divider
   logic all_seen;
   logic any_io;
   always_comb begin
      all_seen = 1'b1;
      any_io = 1'b0;
      for (int c = 0; c < N; c++) begin
         if (func_of(c) != eit_pkg::FN_NONE && is_io(c)) begin
            any_io = 1'b1;
            if (cnt_r[c] == '0) begin
               all_seen = 1'b0;
            end
         end
      end
   end
   logic go_wait;
   // hold the scan open until every general input with a requested result has seen an edge
   assign go_wait = wait_all_results_flag && any_io && !all_seen;
   assign snap = (state_r == eit_pkg::S_IDLE && scan_tick && !go_wait)
                 || (state_r == eit_pkg::S_WAIT && all_seen);

   logic [3:0] ch_r;
   logic [NW-1:0] quo_r;
   logic [TW:0] rem_r;
   logic [TW-1:0] den_r;
   logic [5:0] bit_r;
   logic [TW-1:0] diff;
   logic [TW-1:0] dprev;
   logic [TW-1:0] d1;
   logic [2:0] fn;
   logic [TW:0] rem_sh;
   logic [TW-1:0] hold_val_r;
   logic hold_bad_r;
   // a plain assign would miss config edits while ch_r stands still
   always_comb begin
      fn = func_of(int'(ch_r));
   end
   assign diff = s_last_r[ch_r] - s_before_r[ch_r];
   assign dprev = s_last_r[ch_r] - s_last_r[ch_r - 4'h1];
   assign d1 = s_last_r[ch_r] - s_last_r[0];
   assign rem_sh = {rem_r[TW-1:0], quo_r[NW-1]};

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         state_r <= eit_pkg::S_IDLE;
         ch_r <= '0;
         quo_r <= '0;
         rem_r <= '0;
         den_r <= '0;
         bit_r <= '0;
         hold_val_r <= '0;
         hold_bad_r <= 1'b0;
         result_valid <= 1'b0;
         result_chan <= '0;
         result_value <= '0;
         result_bad <= 1'b0;
         scan_done <= 1'b0;
         scan_skipped <= 1'b0;
         busy <= 1'b0;
      end else begin
         result_valid <= 1'b0;
         scan_done <= 1'b0;
         // a tick while still working is a lost scan
         scan_skipped <= scan_tick && state_r != eit_pkg::S_IDLE;
         unique case (state_r)
            eit_pkg::S_IDLE: begin
               if (snap) begin
                  state_r <= eit_pkg::S_SEL;
                  ch_r <= '0;
                  busy <= 1'b1;
               end else if (scan_tick) begin
                  state_r <= eit_pkg::S_WAIT;
                  busy <= 1'b1;
               end
            end
            eit_pkg::S_WAIT: begin
               if (snap) begin
                  state_r <= eit_pkg::S_SEL;
                  ch_r <= '0;
               end
            end
            eit_pkg::S_SEL: begin
               hold_bad_r <= 1'b0;
               state_r <= eit_pkg::S_EMIT;
               unique case (fn)
                  eit_pkg::FN_PERIOD: begin
                     // mean period = span over edges in scan
                     quo_r <= NW'(diff);
                     den_r <= TW'(s_cnt_r[ch_r]);
                     rem_r <= '0;
                     bit_r <= '0;
                     hold_bad_r <= s_cnt_r[ch_r] == '0
                        || (is_pulse(int'(ch_r)) && diff > TW'(eit_pkg::MAX_PERIOD_TICKS));
                     if (s_cnt_r[ch_r] != '0) begin
                        state_r <= eit_pkg::S_DIV;
                     end
                  end
                  eit_pkg::FN_FREQ: begin
                     // edges per span, scaled to hertz
                     quo_r <= NW'(s_cnt_r[ch_r]) * NW'(eit_pkg::PULSE_TICK_HZ);
                     den_r <= diff;
                     rem_r <= '0;
                     bit_r <= '0;
                     hold_bad_r <= s_cnt_r[ch_r] == '0 || diff == '0
                        || !is_pulse(int'(ch_r));
                     if (s_cnt_r[ch_r] != '0 && diff != '0 && is_pulse(int'(ch_r))) begin
                        state_r <= eit_pkg::S_DIV;
                     end
                  end
                  // delays use the latest edges only; a slow aperiodic input may
                  // be off by half a scan
                  eit_pkg::FN_DLY_PREV: begin
                     hold_val_r <= dprev;
                     hold_bad_r <= ch_r == '0;
                  end
                  eit_pkg::FN_DLY_CH1: begin
                     hold_val_r <= d1;
                  end
                  eit_pkg::FN_EDGES: begin
                     hold_val_r <= TW'(s_cnt_r[ch_r]);
                  end
                  eit_pkg::FN_EDGES_CH1: begin
                     hold_val_r <= TW'(s_since1_r[ch_r]);
                  end
                  default: begin
                     state_r <= (ch_r == 4'hF) ? eit_pkg::S_IDLE : eit_pkg::S_SEL;
                     ch_r <= ch_r + 4'h1;
                     if (ch_r == 4'hF) begin
                        scan_done <= 1'b1;
                        busy <= 1'b0;
                     end
                  end
               endcase
            end
            eit_pkg::S_DIV: begin
               // restoring division, one quotient bit a cycle
               if (rem_sh >= {1'b0, den_r}) begin
                  rem_r <= rem_sh - {1'b0, den_r};
                  quo_r <= {quo_r[NW-2:0], 1'b1};
               end else begin
                  rem_r <= rem_sh;
                  quo_r <= {quo_r[NW-2:0], 1'b0};
               end
               bit_r <= bit_r + 6'h01;
               if (bit_r == 6'(NW - 1)) begin
                  state_r <= eit_pkg::S_EMIT;
               end
            end
            eit_pkg::S_EMIT: begin
               // chan, value and bad change only together with valid
               result_chan <= ch_r;
               result_bad <= hold_bad_r;
               if (fn == eit_pkg::FN_PERIOD || fn == eit_pkg::FN_FREQ) begin
                  result_value <= quo_r[TW-1:0];
               end else begin
                  result_value <= hold_val_r;
               end
               result_valid <= 1'b1;
               ch_r <= ch_r + 4'h1;
               state_r <= (ch_r == 4'hF) ? eit_pkg::S_IDLE : eit_pkg::S_SEL;
               if (ch_r == 4'hF) begin
                  scan_done <= 1'b1;
                  busy <= 1'b0;
               end
            end
            default: begin
               state_r <= eit_pkg::S_IDLE;
            end
         endcase
      end
   end
endmodule

// File: dv/eit_checker_assertions.sv
// eit_checker_assertions: port-level checks of scan handshake and result timing.
// assumes bind onto eit_edge_interval_measure, single clock, reset active high.
`timescale 1ns/1ps
module eit_checker #(
   parameter int IO_BASE_CYC = 4,
   parameter int IO_PER_RESULT_CYC = 6
) (
   input wire logic clk,
   input wire logic reset,
   input wire logic [11:0] fast_pulse_inputs,
   input wire logic [15:0] io_inputs,
   input wire logic [31:0] edge_code_hi,
   input wire logic [31:0] edge_code_lo,
   input wire logic [23:0] func_code_hi,
   input wire logic [23:0] func_code_lo,
   input wire logic wait_all_results_flag,
   input wire logic scan_tick,
   input wire logic result_valid,
   input wire logic [3:0] result_chan,
   input wire logic [31:0] result_value,
   input wire logic result_bad,
   input wire logic scan_done,
   input wire logic scan_skipped,
   input wire logic busy
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);
   ////////////////////////////////////////////////////////////////////////
   sequence s_take;
      scan_tick && !busy;
   endsequence
   sequence s_take_nowait;
      s_take ##0 !wait_all_results_flag;
   endsequence
   // 16 period channels at 50 cycles each stay well under the bound
   a_scan_bounded: assert property (s_take_nowait |-> ##[1:1000] scan_done)
      else $error("scan did not finish in time");
   a_tick_busy: assert property (s_take |=> busy)
      else $error("accepted tick did not raise busy");
   a_skip_busy: assert property (scan_tick && busy |=> scan_skipped)
      else $error("tick while busy not flagged");
   a_skip_cause: assert property (scan_skipped |-> $past(scan_tick) && $past(busy))
      else $error("skip flag without cause");
   a_valid_in_scan: assert property (result_valid |-> busy || scan_done)
      else $error("result outside a scan");
   a_fell_done: assert property ($fell(busy) |-> scan_done)
      else $error("busy dropped without done");
   a_done_pulse: assert property (scan_done |=> !scan_done && !busy)
      else $error("done not a single pulse");
   a_value_holds: assert property (!result_valid |->
      $stable(result_value) && $stable(result_chan) && $stable(result_bad))
      else $error("result changed without valid");
   a_reset_quiet: assert property ($fell(reset) |-> !busy && !result_valid && !scan_done)
      else $error("outputs active after reset");
endmodule

// File: dv/eit_sig_source.sv
// eit_sig_source: square-wave sensor model on every pulse and general input.
// assumes burst is a one-cycle request; lines rest low between bursts.
`timescale 1ns/1ps
module eit_sig_source (
   input wire logic clk,
   input wire logic reset,
   input wire logic burst,
   input wire logic [7:0] periods,
   input wire logic [7:0] half_cyc,
   output logic [11:0] fast_pulse_inputs,
   output logic [15:0] io_inputs,
   output logic active
);
   logic [7:0] left_r;
   logic [7:0] ph_r;
   logic lvl_r;
   ////////////////////////////////////////////////////////////////////////
   // strictly periodic so two-channel delays are exact
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         left_r <= 8'h00;
         ph_r <= 8'h00;
         lvl_r <= 1'b0;
      end else if (burst) begin
         left_r <= periods;
         ph_r <= half_cyc - 8'h01;
         lvl_r <= 1'b1;
      end else if (left_r != 8'h00) begin
         ph_r <= (ph_r == 8'h00) ? half_cyc - 8'h01 : ph_r - 8'h01;
         if (ph_r == 8'h00) begin
            lvl_r <= ~lvl_r;
            left_r <= lvl_r ? left_r - 8'h01 : left_r;
         end
      end
   end
   // same wave everywhere: edges align across channels
   assign fast_pulse_inputs = {12{lvl_r}};
   assign io_inputs = {16{lvl_r}};
   assign active = (left_r != 8'h00);
endmodule

// File: dv/tb_top.sv
// tb_top: scan sequences with expected results for the edge interval timer.
// assumes checker and sensor model compiled first; 200 MHz clock.
`timescale 1ns/1ps
`define CHK(got, exp) begin comparisons++; if ((got) !== (exp)) begin fail_count++; \
   $display("MISMATCH t=%0t got %h exp %h", $time, got, exp); end end
module tb_top;
   logic clk = 1'b0;
   logic reset = 1'b1;
   logic [11:0] fast_pulse_inputs;
   logic [15:0] io_inputs;
   logic [31:0] edge_code_hi = 32'h0, edge_code_lo = 32'h0;
   logic [23:0] func_code_hi = 24'h0, func_code_lo = 24'h0;
   logic wait_all_results_flag = 1'b0, scan_tick = 1'b0, burst = 1'b0, active;
   logic result_valid, result_bad, scan_done, scan_skipped, busy;
   logic [3:0] result_chan;
   logic [31:0] result_value;
   logic [3:0] ed [16];
   logic [2:0] fn [16];
   logic [31:0] got_val [16];
   logic got_bad [16];
   logic got_seen [16];
   int fail_count = 0;
   int comparisons = 0;
   always #2.5 clk = ~clk;
   ////////////////////////////////////////////////////////////////////////
   // short io tick gives the general-input timestamps a fine step
   eit_edge_interval_measure #(.IO_BASE_CYC(4), .IO_PER_RESULT_CYC(6))
      eit_edge_interval_measure_inst (
      .clk(clk), .reset(reset), .fast_pulse_inputs(fast_pulse_inputs), .io_inputs(io_inputs),
      .edge_code_hi(edge_code_hi), .edge_code_lo(edge_code_lo), .func_code_hi(func_code_hi),
      .func_code_lo(func_code_lo), .wait_all_results_flag(wait_all_results_flag),
      .scan_tick(scan_tick), .result_valid(result_valid), .result_chan(result_chan),
      .result_value(result_value), .result_bad(result_bad), .scan_done(scan_done),
      .scan_skipped(scan_skipped), .busy(busy));
   eit_sig_source eit_sig_source_inst (.clk(clk), .reset(reset), .burst(burst),
      .periods(8'h08), .half_cyc(8'h28), .fast_pulse_inputs(fast_pulse_inputs),
      .io_inputs(io_inputs), .active(active));
   ////////////////////////////////////////////////////////////////////////
   task automatic results();
      $display("comparisons %0d mismatches %0d", comparisons, fail_count);
      if (fail_count == 0 && comparisons > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   task automatic apply_cfg();
      for (int i = 0; i < 8; i++) begin
         edge_code_lo[4*i+:4] = ed[i];
         edge_code_hi[4*i+:4] = ed[8+i];
         func_code_lo[3*i+:3] = fn[i];
         func_code_hi[3*i+:3] = fn[8+i];
      end
   endtask
   task automatic pulse(input bit is_burst);
      @(posedge clk);
      #1 if (is_burst) burst = 1'b1; else scan_tick = 1'b1;
      @(posedge clk);
      #1 burst = 1'b0;
      scan_tick = 1'b0;
   endtask
   // gathers one scan; a missing done ends the run
   task automatic collect();
      int n;
      n = 0;
      got_seen = '{default: 1'b0};
      while (scan_done !== 1'b1 && n < 3000) begin
         @(posedge clk);
         #1 n++;
         if (result_valid === 1'b1) begin
            got_val[result_chan] = result_value;
            got_bad[result_chan] = result_bad;
            got_seen[result_chan] = 1'b1;
         end
      end
      if (n >= 3000) begin
         fail_count++;
         $display("MISMATCH t=%0t scan never completed", $time);
         results();
      end
   endtask
   // tick lands between fall 4 and rise 5 so the next scan sees edges 5..8
   task automatic scan_pair();
      int n;
      n = 0;
      pulse(1'b1);
      repeat (298) @(posedge clk);
      pulse(1'b0);
      collect();
      while (active === 1'b1 && n < 2000) begin
         @(posedge clk);
         n++;
      end
      if (n >= 2000) begin
         fail_count++;
         $display("MISMATCH t=%0t source stuck", $time);
         results();
      end
      repeat (10) @(posedge clk);
      pulse(1'b0);
      collect();
   endtask
   ////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (16) @(posedge clk);
      #1 reset = 1'b0;
      `CHK(busy, 1'b0)
      `CHK(result_valid, 1'b0)
      // pulse channels only, every pulse edge code and every function
      ed = '{4'h3, 4'h3, 4'h3, 4'h3, 4'h3, 4'h2, 4'h5, 4'h4,
             4'h2, 4'hF, 4'hF, 4'hF, 4'hF, 4'hF, 4'hF, 4'hF};
      fn = '{3'h1, 3'h3, 3'h4, 3'h5, 3'h2, 3'h5, 3'h5, 3'h5,
             3'h6, 3'h0, 3'h0, 3'h0, 3'h0, 3'h0, 3'h0, 3'h0};
      apply_cfg();
      scan_pair();
      `CHK(got_val[0], 32'h0000000A)
      `CHK(got_bad[0], 1'b0)
      `CHK(got_val[1], 32'h00000000)
      `CHK(got_val[2], 32'h00000000)
      `CHK(got_val[3], 32'h00000004)
      `CHK(got_val[4], 32'h002625A0)
      `CHK(got_val[5], 32'h00000004)
      `CHK(got_val[6], 32'h00000004)
      `CHK(got_val[7], 32'h00000004)
      `CHK(got_val[8], 32'h00000001)
      `CHK(got_seen[9], 1'b0)
      // quiet scan: no edges at all
      pulse(1'b0);
      collect();
      `CHK(got_bad[0], 1'b1)
      `CHK(got_bad[4], 1'b1)
      `CHK(got_val[3], 32'h00000000)
      // general inputs alone, both io edge codes
      ed = '{4'h0, 4'h0, 4'h1, 4'h1, 4'hF, 4'hF, 4'hF, 4'hF,
             4'hF, 4'hF, 4'hF, 4'hF, 4'hF, 4'hF, 4'hF, 4'hF};
      fn = '{3'h4, 3'h3, 3'h2, 3'h3, 3'h0, 3'h0, 3'h0, 3'h0,
             3'h0, 3'h0, 3'h0, 3'h0, 3'h0, 3'h0, 3'h0, 3'h0};
      apply_cfg();
      scan_pair();
      `CHK(got_val[0], 32'h00000000)
      `CHK(got_val[1], 32'h00000000)
      `CHK(got_bad[2], 1'b1)
      `CHK(got_val[3], 32'h00000000)
      `CHK(got_seen[4], 1'b0)
      // wait mode holds the scan open until inputs move
      wait_all_results_flag = 1'b1;
      pulse(1'b0);
      repeat (20) @(posedge clk);
      #1 `CHK(busy, 1'b1)
      pulse(1'b0);
      `CHK(scan_skipped, 1'b1)
      pulse(1'b1);
      collect();
      `CHK(got_seen[0], 1'b1)
      results();
   end
endmodule
bind eit_edge_interval_measure eit_checker #(.IO_BASE_CYC(IO_BASE_CYC),
   .IO_PER_RESULT_CYC(IO_PER_RESULT_CYC)) eit_checker_inst (.clk(clk), .reset(reset),
   .fast_pulse_inputs(fast_pulse_inputs), .io_inputs(io_inputs), .edge_code_hi(edge_code_hi),
   .edge_code_lo(edge_code_lo), .func_code_hi(func_code_hi), .func_code_lo(func_code_lo),
   .wait_all_results_flag(wait_all_results_flag), .scan_tick(scan_tick),
   .result_valid(result_valid), .result_chan(result_chan), .result_value(result_value),
   .result_bad(result_bad), .scan_done(scan_done), .scan_skipped(scan_skipped), .busy(busy));
